/* rtl/rglt_config.sv */
// Gain-lock policy and loop table configuration register block
//
// Overview of operation
// - Policy 0 free, 1 manual, 2 hold, 3 lock
// - Sync word locks only with zero preamble tolerance
// - Source 0 loads ROM tables on tx/rx entry
// - Source 1: custom rx table, ROM tx table
// - Source 2: tx table from packet RAM 0x10-0x18
// - Source 3: custom rx and packet RAM tx
// - Source 1/3 applies both tuning fields to rx
// - Auto tables: narrow rx, rate-based tx bandwidth
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
module rglt_config
    import rglt_pkg::*;
(
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    // Register port
    input  wire logic [9:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [7:0]  o_reg_rdata,
    // Radio state and receiver events
    input  wire rglt_radio_e i_radio_state,
    input  wire logic [1:0]  i_tx_rate_sel,
    input  wire logic        i_preamble_det,
    input  wire logic        i_sync_det,
    input  wire logic [3:0]  i_preamble_tol,
    // Gain control
    output logic             o_gain_manual,
    output logic             o_gain_hold,
    // Packet RAM read port, data one cycle after the request
    output logic             o_pram_rd,
    output logic      [7:0]  o_pram_addr,
    input  wire logic [7:0]  i_pram_data,
    // Loop table writes to the synthesizer
    output rglt_lut_s        o_lut,
    output logic             o_load_busy
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic {RGLT_ST_IDLE, RGLT_ST_LOAD} rglt_fsm_e;

    typedef struct packed {
        logic [7:0]  tune_cfg;
        logic [7:0]  lock_cfg;
        logic [7:0]  rdata;
        rglt_radio_e prev_radio;
        rglt_fsm_e   fsm;
        logic [3:0]  idx;
        logic        pend;
        logic [3:0]  pend_idx;
        logic        load_tx;
        rglt_from_e  from;
        logic        locked;
        rglt_lut_s   lut;
    } rglt_state_s;

    rglt_state_s st_q;
    rglt_state_s st_d;

    rglt_policy_e policy;
    rglt_source_e source;
    logic [5:0]   tune_hi;
    logic [3:0]   tune_lo;
    logic         enter_rx;
    logic         enter_tx;
    logic [6:0]   rom_addr;
    logic [7:0]   rom_data;
    logic [2:0]   tx_set;

    assign policy  = rglt_policy_e'(st_q.lock_cfg[RGLT_POLICY_LSB +: 2]);
    assign source  = rglt_source_e'(st_q.lock_cfg[RGLT_SOURCE_LSB +: 2]);
    assign tune_hi = st_q.tune_cfg[RGLT_TUNE_HI_LSB +: 6];
    assign tune_lo = st_q.lock_cfg[RGLT_TUNE_LO_LSB +: 4];

    // Entry into rx or tx is a change of the radio state
    assign enter_rx = (i_radio_state == RGLT_RADIO_RX)
                   && (st_q.prev_radio != RGLT_RADIO_RX);
    assign enter_tx = (i_radio_state == RGLT_RADIO_TX)
                   && (st_q.prev_radio != RGLT_RADIO_TX);

    // Tx bandwidth set is the rate select plus one
    assign tx_set   = 3'(i_tx_rate_sel) + 3'h1;

    // ------------------------------------------------------------
    // Table memory and packet RAM requests
    // ------------------------------------------------------------
    assign rom_addr = {st_q.load_tx ? tx_set : RGLT_RX_SET, st_q.idx};

    rglt_table_rom u_rom (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_addr    (rom_addr),
        .o_data    (rom_data)
    );

    // Requests are combinational so data lands one cycle later
    assign o_pram_rd   = (st_q.fsm == RGLT_ST_LOAD)
                      && (st_q.from == RGLT_FROM_PRAM);
    assign o_pram_addr = RGLT_PRAM_BASE + {4'h0, st_q.idx};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_d            = st_q;
        st_d.prev_radio = i_radio_state;
        st_d.lut.wr     = 1'b0;
        st_d.pend       = 1'b0;
        st_d.rdata      = 8'h00;

        // Register writes
        if (i_reg_wr && i_reg_addr == RGLT_OFS_TUNE_CFG)
            st_d.tune_cfg = i_reg_wdata;
        if (i_reg_wr && i_reg_addr == RGLT_OFS_LOCK_CFG)
            st_d.lock_cfg = i_reg_wdata;

        // Register reads, unmapped addresses read zero
        if (i_reg_rd)
        begin
            case (i_reg_addr)
                RGLT_OFS_TUNE_CFG: st_d.rdata = st_q.tune_cfg;
                RGLT_OFS_LOCK_CFG: st_d.rdata = st_q.lock_cfg;
                RGLT_OFS_STATUS:   st_d.rdata = {4'h0, st_q.load_tx,
                                                 st_q.locked, o_gain_hold,
                                                 o_load_busy};
                default:           st_d.rdata = 8'h00;
            endcase
        end

        // Lock stays until rx is left or the policy changes
        if (policy != RGLT_POL_LOCK || i_radio_state != RGLT_RADIO_RX)
            st_d.locked = 1'b0;
        else if (i_preamble_det)
            st_d.locked = 1'b1;
        else if (i_sync_det && i_preamble_tol == 4'h0)
            st_d.locked = 1'b1;

        // Output stage: one entry per cycle after the read latency
        if (st_q.pend)
        begin
            st_d.lut.wr    = 1'b1;
            st_d.lut.is_tx = st_q.load_tx;
            st_d.lut.idx   = st_q.pend_idx;
            case (st_q.from)
                RGLT_FROM_PRAM: st_d.lut.data = i_pram_data;
                RGLT_FROM_CALC: st_d.lut.data =
                    rglt_rx_custom(st_q.pend_idx, tune_hi, tune_lo);
                default:        st_d.lut.data = rom_data;
            endcase
        end

        // Table load sequencer
        case (st_q.fsm)
            RGLT_ST_IDLE:
            begin
                st_d.idx = 4'h0;
            end
            RGLT_ST_LOAD:
            begin
                st_d.pend     = 1'b1;
                st_d.pend_idx = st_q.idx;
                st_d.idx      = st_q.idx + 4'h1;
                if (st_q.idx == RGLT_TBL_LAST)
                    st_d.fsm = RGLT_ST_IDLE;
            end
            default:
            begin
                st_d.fsm = RGLT_ST_IDLE;
            end
        endcase

        // A new entry restarts the load with the source of that moment
        if (enter_tx)
        begin
            st_d.fsm     = RGLT_ST_LOAD;
            st_d.idx     = 4'h0;
            st_d.load_tx = 1'b1;
            if (source == RGLT_SRC_TX_CUST || source == RGLT_SRC_BOTH)
                st_d.from = RGLT_FROM_PRAM;
            else
                st_d.from = RGLT_FROM_ROM;
        end
        else if (enter_rx)
        begin
            st_d.fsm     = RGLT_ST_LOAD;
            st_d.idx     = 4'h0;
            st_d.load_tx = 1'b0;
            if (source == RGLT_SRC_RX_CUST || source == RGLT_SRC_BOTH)
                st_d.from = RGLT_FROM_CALC;
            else
                st_d.from = RGLT_FROM_ROM;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            st_q          <= '0;
            st_q.tune_cfg <= RGLT_RST_TUNE_CFG;
            st_q.lock_cfg <= RGLT_RST_LOCK_CFG;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Gain control follows the policy field
    assign o_gain_manual = (policy == RGLT_POL_MANUAL);
    // A lock left from policy 3 must not hold gain once the policy changes
    assign o_gain_hold   = (policy == RGLT_POL_HOLD)
                        || (policy == RGLT_POL_LOCK && st_q.locked);
    assign o_reg_rdata   = st_q.rdata;
    assign o_lut         = st_q.lut;
    assign o_load_busy   = (st_q.fsm == RGLT_ST_LOAD) || st_q.pend;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    a_policy_hold: assert property (
        policy == RGLT_POL_HOLD |-> o_gain_hold && !o_gain_manual)
        else $error("hold policy does not hold gain");
    a_policy_free: assert property (
        policy == RGLT_POL_FREE |-> !o_gain_hold && !o_gain_manual)
        else $error("free policy holds gain");
    a_sync_tol_lock: assert property (
        policy == RGLT_POL_LOCK && i_radio_state == RGLT_RADIO_RX
        && !i_reg_wr && i_sync_det && !i_preamble_det
        && i_preamble_tol != 4'h0 && !st_q.locked |=> !o_gain_hold)
        else $error("sync locked with nonzero tolerance");
    a_rom_load_seq: assert property (
        enter_tx && source == RGLT_SRC_ROM |-> ##3
        (o_lut.wr && o_lut.is_tx && o_lut.idx == 4'h0
        && o_lut.data == rglt_rom_word({tx_set, 4'h0}))
        ##8 (o_lut.wr && o_lut.idx == RGLT_TBL_LAST))
        else $error("rom tx table not loaded in nine cycles");
    a_rx_custom_word: assert property (
        enter_rx && source == RGLT_SRC_RX_CUST && !i_reg_wr
        ##1 !i_reg_wr ##1 !i_reg_wr |-> ##1
        (o_lut.wr && !o_lut.is_tx
        && o_lut.data == rglt_rx_custom(4'h0, tune_hi, tune_lo)))
        else $error("custom rx entry wrong");
    a_pram_first: assert property (
        enter_tx && source == RGLT_SRC_TX_CUST |=>
        o_pram_rd && o_pram_addr == RGLT_PRAM_BASE)
        else $error("custom tx load not from first location");
    a_pram_last: assert property (
        enter_tx && source == RGLT_SRC_BOTH && !enter_rx |-> ##9
        (o_pram_rd && o_pram_addr == 8'h18) ##1 !o_pram_rd)
        else $error("custom tx load does not end at last location");
    a_rx_no_tune: assert property (
        enter_rx && (source == RGLT_SRC_ROM || source == RGLT_SRC_TX_CUST)
        |-> ##3 (o_lut.wr && o_lut.data == rglt_rom_word(7'h00)))
        else $error("rom rx table altered by tuning");
    a_rx_never_pram: assert property (
        st_q.fsm == RGLT_ST_LOAD && !st_q.load_tx |-> !o_pram_rd)
        else $error("rx table read from packet ram");

    c_rom_tx_load: cover property (enter_tx && source == RGLT_SRC_ROM);
    c_custom_rx:   cover property (enter_rx && source == RGLT_SRC_BOTH);
    c_sync_lock:   cover property (!st_q.locked && i_sync_det ##1
                                   st_q.locked);

endmodule : rglt_config

/* rtl/rglt_pkg.sv */
// Package: offsets, fields, resets, states and table helpers for rglt
package rglt_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [9:0] RGLT_OFS_TUNE_CFG = 10'h112;
    localparam logic [9:0] RGLT_OFS_LOCK_CFG = 10'h113;
    localparam logic [9:0] RGLT_OFS_STATUS   = 10'h1f0;
    localparam logic [7:0] RGLT_RST_TUNE_CFG = 8'h00;
    localparam logic [7:0] RGLT_RST_LOCK_CFG = 8'h00;

    // Field positions of the lock/table register
    localparam int RGLT_POLICY_LSB = 6;
    localparam int RGLT_SOURCE_LSB = 4;
    localparam int RGLT_TUNE_LO_LSB = 0;
    // Field position of the high tuning field in the neighbour register
    localparam int RGLT_TUNE_HI_LSB = 2;

    // ------------------------------------------------------------
    // Table geometry
    // ------------------------------------------------------------
    localparam logic [3:0] RGLT_TBL_LAST  = 4'h8;  // Nine entries
    localparam logic [7:0] RGLT_PRAM_BASE = 8'h10; // Custom tx table
    localparam logic [2:0] RGLT_RX_SET    = 3'h0;  // Narrow rx set
    localparam logic [7:0] RGLT_ROM_SEED  = 8'h21; // Arbitrary contents
    localparam logic [7:0] RGLT_ROM_STEP  = 8'h07;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RGLT_POL_FREE, RGLT_POL_MANUAL, RGLT_POL_HOLD, RGLT_POL_LOCK
    } rglt_policy_e;

    typedef enum logic [1:0] {
        RGLT_SRC_ROM, RGLT_SRC_RX_CUST, RGLT_SRC_TX_CUST, RGLT_SRC_BOTH
    } rglt_source_e;

    typedef enum logic [1:0] {
        RGLT_RADIO_IDLE, RGLT_RADIO_RX, RGLT_RADIO_TX, RGLT_RADIO_SLEEP
    } rglt_radio_e;

    typedef enum logic [1:0] {
        RGLT_FROM_ROM, RGLT_FROM_PRAM, RGLT_FROM_CALC
    } rglt_from_e;

    typedef struct packed {
        logic       wr;
        logic       is_tx;
        logic [3:0] idx;
        logic [7:0] data;
    } rglt_lut_s;

    // Contents of the built-in table memory
    function automatic logic [7:0] rglt_rom_word(input logic [6:0] a);
        rglt_rom_word = 8'({1'b0, a} * RGLT_ROM_STEP + RGLT_ROM_SEED);
    endfunction : rglt_rom_word

    // Custom rx entry built from both tuning fields
    function automatic logic [7:0] rglt_rx_custom(input logic [3:0] idx,
                                                  input logic [5:0] hi,
                                                  input logic [3:0] lo);
        rglt_rx_custom = 8'({hi, 2'b00} + {4'h0, lo} + {4'h0, idx});
    endfunction : rglt_rx_custom

endpackage : rglt_pkg

/* rtl/rglt_table_rom.sv */
// Built-in loop table memory with registered read data
`timescale 1ns/1ps
module rglt_table_rom
    import rglt_pkg::*;
(
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst,
    // Read port
    input  wire logic [6:0] i_addr,
    output logic      [7:0] o_data
);

    // ------------------------------------------------------------
    // Contents and read register
    // ------------------------------------------------------------
    logic [7:0] rom_mem [128];

    // Contents are constant, filled from the package function
    always_comb
    begin
        for (int i = 0; i < 128; i++)
        begin
            rom_mem[i] = rglt_rom_word(7'(i));
        end
    end

    // One cycle read latency
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_data <= 8'h00;
        end
        else
        begin
            o_data <= rom_mem[i_addr];
        end
    end

endmodule : rglt_table_rom

/* sim/rglt_config_tb_top.sv */
// Self-checking bench for the gain-lock and loop table register block
`timescale 1ns/1ps
module rglt_config_tb_top
    import rglt_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk;
    logic        rst;
    logic [9:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    rglt_radio_e radio;
    logic [1:0]  rate;
    logic        pre_det;
    logic        sync_det;
    logic [3:0]  tol;
    logic        g_manual;
    logic        g_hold;
    logic        pram_rd;
    logic [7:0]  pram_addr;
    logic [7:0]  pram_data;
    rglt_lut_s   lut;
    logic        busy;
    int          fails;
    int          samples_checked;

    rglt_config i_dut (
        .i_ref_clk     (clk),
        .i_rst         (rst),
        .i_reg_addr    (addr),
        .i_reg_wdata   (wdata),
        .i_reg_wr      (wr),
        .i_reg_rd      (rd),
        .o_reg_rdata   (rdata),
        .i_radio_state (radio),
        .i_tx_rate_sel (rate),
        .i_preamble_det(pre_det),
        .i_sync_det    (sync_det),
        .i_preamble_tol(tol),
        .o_gain_manual (g_manual),
        .o_gain_hold   (g_hold),
        .o_pram_rd     (pram_rd),
        .o_pram_addr   (pram_addr),
        .i_pram_data   (pram_data),
        .o_lut         (lut),
        .o_load_busy   (busy)
    );

    // ------------------------------------------------------------
    // Clock and packet RAM stand-in
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Data one cycle after the request; scrambled when idle so a stale
    // word can never pass for a fresh one
    always @(posedge clk)
        pram_data <= pram_rd ? (pram_addr ^ 8'h5a) : ~pram_data;

    // ------------------------------------------------------------
    // Compare, bus and closing tasks
    // ------------------------------------------------------------
    task automatic chk_byte(string what, logic [7:0] exp, logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_byte

    task automatic chk_bit(string what, logic exp, logic got);
        chk_byte(what, {7'h0, exp}, {7'h0, got});
    endtask : chk_bit

    task automatic reg_wr(logic [9:0] a, logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
        #1;
    endtask : reg_wr

    task automatic reg_rd(logic [9:0] a, output logic [7:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_rd

    task automatic summarize;
        if (fails == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Reset values, read-back and an unmapped address
    task automatic test_regs;
        logic [7:0] d;
        reg_rd(RGLT_OFS_LOCK_CFG, d);
        chk_byte("lock cfg reset", RGLT_RST_LOCK_CFG, d);
        reg_rd(RGLT_OFS_TUNE_CFG, d);
        chk_byte("tune cfg reset", RGLT_RST_TUNE_CFG, d);
        reg_wr(10'h000, 8'hff);
        reg_rd(10'h000, d);
        chk_byte("unmapped read", 8'h00, d);
        reg_wr(RGLT_OFS_LOCK_CFG, 8'ha5);
        reg_rd(RGLT_OFS_LOCK_CFG, d);
        chk_byte("lock cfg readback", 8'ha5, d);
        reg_rd(RGLT_OFS_STATUS, d);
        chk_byte("status hold", 8'h02, d);
    endtask : test_regs

    // Every policy code and its gain outputs while idle
    task automatic test_policy;
        for (int p = 0; p < 4; p++)
        begin
            reg_wr(RGLT_OFS_LOCK_CFG, 8'(p << RGLT_POLICY_LSB));
            chk_bit("gain manual", p == 1, g_manual);
            chk_bit("gain hold", p == 2, g_hold);
        end
    endtask : test_policy

    // Lock after detection; sync only counts with zero tolerance
    task automatic test_lock;
        reg_wr(RGLT_OFS_LOCK_CFG, 8'hc0);
        @(posedge clk);
        radio    <= RGLT_RADIO_RX;
        tol      <= 4'h1;
        sync_det <= 1'b1;
        @(posedge clk);
        sync_det <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk_bit("hold on sync tol1", 1'b0, g_hold);
        @(posedge clk);
        tol      <= 4'h0;
        sync_det <= 1'b1;
        @(posedge clk);
        sync_det <= 1'b0;
        #1;
        chk_bit("hold on sync tol0", 1'b1, g_hold);
        @(posedge clk);
        radio <= RGLT_RADIO_IDLE;
        repeat (15) @(posedge clk);
        #1;
        chk_bit("hold after rx exit", 1'b0, g_hold);
        @(posedge clk);
        radio   <= RGLT_RADIO_RX;
        tol     <= 4'h3;
        pre_det <= 1'b1;
        @(posedge clk);
        pre_det <= 1'b0;
        #1;
        chk_bit("hold on preamble", 1'b1, g_hold);
        reg_wr(RGLT_OFS_LOCK_CFG, 8'h00);
        #1;
        chk_bit("hold after policy 0", 1'b0, g_hold);
        @(posedge clk);
        radio <= RGLT_RADIO_IDLE;
        repeat (15) @(posedge clk);
    endtask : test_lock

    // Enter rx or tx and judge the nine table words that follow
    task automatic load_check(logic [1:0] src, rglt_radio_e st,
                              logic [1:0] r, logic [3:0] lo,
                              logic [5:0] hi);
        int         n;
        logic       tx;
        logic [7:0] exp;
        logic [2:0] set;
        n   = 0;
        tx  = (st == RGLT_RADIO_TX);
        set = tx ? 3'(r) + 3'h1 : 3'h0;
        reg_wr(RGLT_OFS_TUNE_CFG, {hi, 2'b00});
        reg_wr(RGLT_OFS_LOCK_CFG, {2'b00, src, lo});
        @(posedge clk);
        rate  <= r;
        radio <= st;
        for (int k = 0; k < 20 && n < 9; k++)
        begin
            @(posedge clk);
            #1;
            if (lut.wr === 1'b1)
            begin
                if (tx && src[1])
                    exp = (8'h10 + 8'(n)) ^ 8'h5a;
                else if (!tx && src[0])
                    exp = {hi, 2'b00} + 8'(lo) + 8'(n);
                else
                    exp = 8'(({set, 4'(n)}) * 7 + 8'h21);
                chk_byte("lut idx", 8'(n), {4'h0, lut.idx});
                chk_bit("lut is_tx", tx, lut.is_tx);
                chk_bit("busy in load", n < 8, busy);
                chk_byte("lut data", exp, lut.data);
                n++;
            end
        end
        chk_byte("lut word count", 8'd9, 8'(n));
        @(posedge clk);
        #1;
        chk_bit("busy after load", 1'b0, busy);
        @(posedge clk);
        radio <= RGLT_RADIO_IDLE;
        repeat (3) @(posedge clk);
    endtask : load_check

    task automatic test_src0;
        load_check(2'd0, RGLT_RADIO_RX, 2'd0, 4'h0, 6'h00);
        load_check(2'd0, RGLT_RADIO_TX, 2'd2, 4'h0, 6'h00);
    endtask : test_src0

    task automatic test_src1;
        load_check(2'd1, RGLT_RADIO_RX, 2'd0, 4'h5, 6'h2a);
        load_check(2'd1, RGLT_RADIO_TX, 2'd3, 4'h5, 6'h2a);
    endtask : test_src1

    task automatic test_src2;
        // Sleep loses the custom table; the stand-in serves the rewritten one
        @(posedge clk);
        radio <= RGLT_RADIO_SLEEP;
        repeat (3) @(posedge clk);
        radio <= RGLT_RADIO_IDLE;
        load_check(2'd2, RGLT_RADIO_TX, 2'd1, 4'h0, 6'h00);
        load_check(2'd2, RGLT_RADIO_RX, 2'd1, 4'h0, 6'h00);
    endtask : test_src2

    task automatic test_src3;
        load_check(2'd3, RGLT_RADIO_RX, 2'd0, 4'hf, 6'h3f);
        load_check(2'd3, RGLT_RADIO_TX, 2'd0, 4'hf, 6'h3f);
    endtask : test_src3

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        fails           = 0;
        samples_checked = 0;
        rst      = 1'b1;
        addr     = 10'h000;
        wdata    = 8'h00;
        wr       = 1'b0;
        rd       = 1'b0;
        radio    = RGLT_RADIO_IDLE;
        rate     = 2'd0;
        pre_det  = 1'b0;
        sync_det = 1'b0;
        tol      = 4'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        test_regs();
        test_policy();
        test_lock();
        test_src0();
        test_src1();
        test_src2();
        test_src3();
        summarize();
    end

    // The whole run needs well under a thousand cycles
    initial
    begin
        #100000;
        fails++;
        summarize();
    end

endmodule : rglt_config_tb_top
